//--- mmfw_defs.vh
`ifndef MMFW_DEFS_VH
`define MMFW_DEFS_VH

// CPU mode encodings.
`define MMFW_MODE_BOOT 3'h0
`define MMFW_MODE_TEST 3'h1
`define MMFW_MODE_COS 3'h2
`define MMFW_MODE_SYS 3'h3
`define MMFW_MODE_USER 3'h4

// Internal mode bit patterns; any other pattern defers to the status word.
`define MMFW_MBITS_BOOT 2'h1
`define MMFW_MBITS_TEST 2'h2
`define MMFW_MBITS_BOOT2 2'h3

// Status word high bit positions.
`define MMFW_SW_SYS_BIT 7
`define MMFW_SW_COS_BIT 6

// Memory operations.
`define MMFW_OP_READ 2'h0
`define MMFW_OP_WRITE 2'h1
`define MMFW_OP_EXEC 2'h2

// Segment table entry layout.
`define MMFW_ENT_W 65
`define MMFW_ENT_BYTES 16
`define MMFW_ENT_R 0
`define MMFW_ENT_X 2
`define MMFW_ENT_RWX_HI 2
`define MMFW_ENT_HWR 3
`define MMFW_ENT_HWW 4
`define MMFW_ENT_FIRST_LO 5
`define MMFW_ENT_FIRST_HI 24
`define MMFW_ENT_LAST_LO 25
`define MMFW_ENT_LAST_HI 44
`define MMFW_ENT_OFFS_LO 45
`define MMFW_ENT_OFFS_HI 64

// Physical memory map.
`define MMFW_ROM_END 20'h3FFFF
`define MMFW_TROM_END 20'h07FFF
`define MMFW_EE_BASE 20'h40000
`define MMFW_EE_END 20'h7FFFF
`define MMFW_RAM_BASE 20'h80000
`define MMFW_RAM_END 20'h8FFFF
`define MMFW_MFR_EE_BYTES 20'h00080

// Register space group bounds.
`define MMFW_G_CPU_LO 8'h80
`define MMFW_G_CPU_HI 8'h8F
`define MMFW_G_SYS_LO 8'h90
`define MMFW_G_SYS_HI 8'h9F
`define MMFW_G_SEG_LO 8'hA0
`define MMFW_G_SEG_HI 8'hA7
`define MMFW_G_FW_LO 8'hA8
`define MMFW_G_FW_HI 8'hAF
`define MMFW_G_COSI_LO 8'hB0
`define MMFW_G_COSI_HI 8'hB7
`define MMFW_G_HW_LO 8'hC0
`define MMFW_HW_SUB_HI 5
`define MMFW_HW_SUB_LO 3

// Register addresses.
`define MMFW_A_STATUS_WORD_HIGH 8'h90
`define MMFW_A_TBL_PTR_LOW 8'hA0
`define MMFW_A_TBL_PTR_HIGH 8'hA1
`define MMFW_A_FW_CTRL_LOW 8'hA8
`define MMFW_A_FW_CTRL_HIGH 8'hA9
`define MMFW_A_XW_BASE_LOW 8'hAA
`define MMFW_A_XW_BASE_HIGH 8'hAB
`define MMFW_A_XW_SIZE_LOW 8'hAC
`define MMFW_A_XW_SIZE_HIGH 8'hAD

// Reset values.
`define MMFW_RST_TBL_PTR 16'h0000
`define MMFW_RST_FW_CTRL 8'h00
`define MMFW_RST_XW 16'h0000

`endif

//--- mmfw_seg_mem.v
`timescale 1ns/1ps
`default_nettype none

module mmfw_seg_mem #(
	parameter W = 65,
	parameter DEPTH = 64,
	parameter AW = 6
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata
);

	reg [W-1:0] mem [0:DEPTH-1];
	integer i;

	// Entries start cleared so that unwritten segments grant nothing.
	initial
	begin
		for (i = 0; i < DEPTH; i = i + 1)
			mem[i] = {W{1'b0}};
		rdata = {W{1'b0}};
	end

	always @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule // mmfw_seg_mem

`default_nettype wire

//--- mmfw_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "mmfw_defs.vh"

// Function
// - Mode (five kinds) comes from status word high plus two internal bits.
// - Table holds rights, first and last address, offset for 64 segments.
// - Each entry also holds hardware register group rights.
// - An entry granting nothing is disabled and matches nothing.
// - Any number of defined segments up to 64 works.
// - Every CPU address is translated before reaching memory.
// - Access is performed only after the permission check passes.
// - Checks cover all modes, all memories, read, write and execute.
// - Every register access is checked in hardware against the mode.
// - User mode uses segment rights; contactless mode uses firewall rights.
// - Denied register reads return zero.
// - Denied register writes are dropped.
// - Firewall registers set contactless rights; window registers set exchange RAM.
// - RAM and EEPROM split into contactless and application partitions.
// - Without contactless OS: 128 EEPROM bytes reserved, all RAM open.
// - Table memory locations are themselves protected from user mode and from the exchange window.
// - Segmentation registers hold the table location pointer.
// - Segmentation registers are reachable only in system mode.
// - General CPU registers are reachable in every mode.
// - User mode memory rights come only from the segment table.
// - Contactless mode may use the application RAM exchange window.

module mmfw_unit #(
	parameter NSEG = 64,
	parameter AW = 6
) (
	input wire SYS_CLK,
	input wire RESET_N,
	input wire INSTR_START,
	input wire [7:0] STATUS_WORD_HIGH,
	input wire [1:0] MODE_BITS,
	input wire CFG_COS_PRESENT,
	input wire [19:0] CFG_COS_EE_SIZE,
	input wire [19:0] CFG_COS_RAM_SIZE,
	input wire MEM_REQ,
	input wire [1:0] MEM_OP,
	input wire [19:0] MEM_VADDR,
	output wire PHYS_REQ,
	output wire PHYS_WE,
	output wire [19:0] PHYS_ADDR,
	output wire MEM_DONE,
	output wire MEM_FAULT,
	input wire TBL_WE,
	input wire [AW-1:0] TBL_INDEX,
	input wire [`MMFW_ENT_W-1:0] TBL_WDATA,
	input wire SFR_REQ,
	input wire SFR_WE,
	input wire [7:0] SFR_ADDR,
	input wire [7:0] SFR_WDATA,
	input wire [7:0] SFR_FWD_RDATA,
	output wire SFR_FWD_RE,
	output wire SFR_FWD_WE,
	output wire [7:0] SFR_FWD_ADDR,
	output wire [7:0] SFR_FWD_WDATA,
	output wire [7:0] SFR_RDATA,
	output wire SFR_ACK,
	output wire SFR_DENIED,
	output wire [2:0] CPU_MODE,
	output wire [AW-1:0] EXEC_SEG
);

	localparam S_IDLE = 2'h0;
	localparam S_RD = 2'h1;
	localparam S_CMP = 2'h2;
	localparam S_CHK = 2'h3;
	localparam integer TBL_BYTES_I = NSEG * `MMFW_ENT_BYTES;
	localparam integer LAST_IDX_I = NSEG - 1;
	localparam [19:0] TBL_BYTES = TBL_BYTES_I[19:0];
	localparam [AW-1:0] LAST_IDX = LAST_IDX_I[AW-1:0];

	reg cos_s1_q, cos_q;
	reg [19:0] ee_s1_q, ee_sz_q, ram_s1_q, ram_sz_q;
	reg [2:0] mode_q, mode_d;
	reg [1:0] st_q;
	reg [1:0] op_q;
	reg [19:0] va_q, pa_q;
	reg [AW-1:0] idx_q, exec_seg_q, hit_idx_q;
	reg hit_q;
	reg [2:0] segr_q;
	reg [1:0] seg_hw_q, exec_hw_q;
	reg phys_req_q, phys_we_q, done_q, fault_q;
	reg [19:0] phys_addr_q;
	reg [15:0] tbl_ptr_q, xw_base_q, xw_size_q;
	reg [7:0] fw_lo_q, fw_hi_q;
	reg fwd_re_q, fwd_we_q;
	reg [7:0] fwd_addr_q, fwd_wdata_q;
	reg s1_v_q, s1_we_q, s1_ok_q, s1_own_q;
	reg [7:0] s1_rd_q;
	reg [7:0] sfr_rdata_q;
	reg ack_q, denied_q;
	wire [`MMFW_ENT_W-1:0] ent;
	wire tbl_we;

	// Pins from the delivery configuration pass two flip-flops.
	always @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			cos_s1_q <= 1'b0;
			cos_q <= 1'b0;
			ee_s1_q <= 20'h00000;
			ee_sz_q <= 20'h00000;
			ram_s1_q <= 20'h00000;
			ram_sz_q <= 20'h00000;
		end
		else
		begin
			cos_s1_q <= CFG_COS_PRESENT;
			cos_q <= cos_s1_q;
			ee_s1_q <= CFG_COS_EE_SIZE;
			ee_sz_q <= ee_s1_q;
			ram_s1_q <= CFG_COS_RAM_SIZE;
			ram_sz_q <= ram_s1_q;
		end
	end

	// Contactless mode is suppressed when the variant lacks it.
	always @*
	begin
		case (MODE_BITS)
			`MMFW_MBITS_BOOT: mode_d = `MMFW_MODE_BOOT;
			`MMFW_MBITS_TEST: mode_d = `MMFW_MODE_TEST;
			`MMFW_MBITS_BOOT2: mode_d = `MMFW_MODE_BOOT;
			default:
			begin
				if (STATUS_WORD_HIGH[`MMFW_SW_COS_BIT] && cos_q)
					mode_d = `MMFW_MODE_COS;
				else if (STATUS_WORD_HIGH[`MMFW_SW_SYS_BIT])
					mode_d = `MMFW_MODE_SYS;
				else
					mode_d = `MMFW_MODE_USER;
			end
		endcase
	end

	always @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			mode_q <= `MMFW_MODE_BOOT;
		else if (INSTR_START)
			mode_q <= mode_d;
	end

	// Only system mode may rewrite the table image.
	assign tbl_we = TBL_WE && (mode_q == `MMFW_MODE_SYS);

	mmfw_seg_mem #(
		.W(`MMFW_ENT_W),
		.DEPTH(NSEG),
		.AW(AW)
	) u_tbl (
		.clk(SYS_CLK),
		.we(tbl_we),
		.waddr(TBL_INDEX),
		.wdata(TBL_WDATA),
		.raddr(idx_q),
		.rdata(ent)
	);

	// Physical region decode of the translated address.
	reg in_rom, in_trom, in_ee, in_ram, in_cee, in_cram, in_win, in_tbl;
	reg [19:0] ee_rel, ram_rel, tbl_base, tbl_rel, ee_lim, ram_lim, xw_end;
	reg op_w, op_x, app_ok, cos_ok, allow;
	always @*
	begin
		ee_rel = pa_q - `MMFW_EE_BASE;
		ram_rel = pa_q - `MMFW_RAM_BASE;
		tbl_base = {tbl_ptr_q, 4'h0};
		tbl_rel = pa_q - tbl_base;
		ee_lim = cos_q ? ee_sz_q : `MMFW_MFR_EE_BYTES;
		ram_lim = cos_q ? ram_sz_q : 20'h00000;
		xw_end = {4'h0, xw_base_q} + {4'h0, xw_size_q};
		in_rom = pa_q <= `MMFW_ROM_END;
		in_trom = pa_q <= `MMFW_TROM_END;
		in_ee = (pa_q >= `MMFW_EE_BASE) && (pa_q <= `MMFW_EE_END);
		in_ram = (pa_q >= `MMFW_RAM_BASE) && (pa_q <= `MMFW_RAM_END);
		in_cee = in_ee && (ee_rel < ee_lim);
		in_cram = in_ram && (ram_rel < ram_lim);
		in_win = in_ram && !in_cram && (ram_rel >= {4'h0, xw_base_q}) && (ram_rel < xw_end);
		in_tbl = (pa_q >= tbl_base) && (tbl_rel < TBL_BYTES);
		op_w = op_q == `MMFW_OP_WRITE;
		op_x = op_q == `MMFW_OP_EXEC;
		app_ok = (in_rom && !in_trom && !op_w) || (in_ee && !in_cee)
			|| (in_ram && !in_cram && !op_x);
		cos_ok = (in_trom && !op_w) || in_cee || (in_cram && !op_x);
		case (mode_q)
			`MMFW_MODE_TEST: allow = (in_rom && !op_w) || in_ee || (in_ram && !op_x);
			`MMFW_MODE_BOOT: allow = cos_ok;
			`MMFW_MODE_COS: allow = cos_ok || (in_win && !op_x && !in_tbl);
			`MMFW_MODE_SYS: allow = app_ok;
			`MMFW_MODE_USER: allow = app_ok && hit_q && segr_q[op_q] && !in_tbl;
			default: allow = 1'b0;
		endcase
		if (op_q > `MMFW_OP_EXEC)
			allow = 1'b0;
	end

	// Translation walk: user mode scans the table, one entry per two cycles.
	wire ent_on = |ent[`MMFW_ENT_RWX_HI:`MMFW_ENT_R];
	wire ent_hit = ent_on
		&& (va_q >= ent[`MMFW_ENT_FIRST_HI:`MMFW_ENT_FIRST_LO])
		&& (va_q <= ent[`MMFW_ENT_LAST_HI:`MMFW_ENT_LAST_LO]);

	always @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			st_q <= S_IDLE;
			op_q <= `MMFW_OP_READ;
			va_q <= 20'h00000;
			pa_q <= 20'h00000;
			idx_q <= {AW{1'b0}};
			hit_idx_q <= {AW{1'b0}};
			exec_seg_q <= {AW{1'b0}};
			hit_q <= 1'b0;
			segr_q <= 3'h0;
			seg_hw_q <= 2'h0;
			exec_hw_q <= 2'h0;
			phys_req_q <= 1'b0;
			phys_we_q <= 1'b0;
			phys_addr_q <= 20'h00000;
			done_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			phys_req_q <= 1'b0;
			done_q <= 1'b0;
			fault_q <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					if (MEM_REQ)
					begin
						op_q <= MEM_OP;
						va_q <= MEM_VADDR;
						idx_q <= {AW{1'b0}};
						hit_q <= 1'b0;
						segr_q <= 3'h0;
						seg_hw_q <= 2'h0;
						if (mode_q == `MMFW_MODE_USER)
							st_q <= S_RD;
						else
						begin
							// Privileged modes translate one to one.
							pa_q <= MEM_VADDR;
							hit_q <= 1'b1;
							st_q <= S_CHK;
						end
					end
				end
				S_RD:
					st_q <= S_CMP;
				S_CMP:
				begin
					if (ent_hit)
					begin
						hit_q <= 1'b1;
						hit_idx_q <= idx_q;
						pa_q <= va_q + ent[`MMFW_ENT_OFFS_HI:`MMFW_ENT_OFFS_LO];
						segr_q <= ent[`MMFW_ENT_RWX_HI:`MMFW_ENT_R];
						seg_hw_q <= ent[`MMFW_ENT_HWW:`MMFW_ENT_HWR];
						st_q <= S_CHK;
					end
					else if (idx_q == LAST_IDX)
						st_q <= S_CHK;
					else
					begin
						idx_q <= idx_q + 1'b1;
						st_q <= S_RD;
					end
				end
				S_CHK:
				begin
					done_q <= 1'b1;
					st_q <= S_IDLE;
					if (allow)
					begin
						phys_req_q <= 1'b1;
						phys_we_q <= op_w;
						phys_addr_q <= pa_q;
						if (op_x && mode_q == `MMFW_MODE_USER)
						begin
							exec_seg_q <= hit_idx_q;
							exec_hw_q <= seg_hw_q;
						end
					end
					else
						fault_q <= 1'b1;
				end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	// Register access decode and rights.
	reg g_cpu, g_sys, g_seg, g_fw, g_cosi, g_hw, is_status_word_high, own, rd_ok, wr_ok, ok;
	reg [2:0] sub;
	reg [7:0] own_rd;
	always @*
	begin
		g_cpu = (SFR_ADDR >= `MMFW_G_CPU_LO) && (SFR_ADDR <= `MMFW_G_CPU_HI);
		g_sys = (SFR_ADDR >= `MMFW_G_SYS_LO) && (SFR_ADDR <= `MMFW_G_SYS_HI);
		g_seg = (SFR_ADDR >= `MMFW_G_SEG_LO) && (SFR_ADDR <= `MMFW_G_SEG_HI);
		g_fw = (SFR_ADDR >= `MMFW_G_FW_LO) && (SFR_ADDR <= `MMFW_G_FW_HI);
		g_cosi = (SFR_ADDR >= `MMFW_G_COSI_LO) && (SFR_ADDR <= `MMFW_G_COSI_HI);
		g_hw = SFR_ADDR >= `MMFW_G_HW_LO;
		is_status_word_high = SFR_ADDR == `MMFW_A_STATUS_WORD_HIGH;
		sub = SFR_ADDR[`MMFW_HW_SUB_HI:`MMFW_HW_SUB_LO];
		own = g_seg || g_fw;
		case (mode_q)
			`MMFW_MODE_BOOT, `MMFW_MODE_TEST:
			begin
				rd_ok = !g_seg;
				wr_ok = !g_seg;
			end
			`MMFW_MODE_SYS:
			begin
				rd_ok = g_cpu || g_sys || g_seg || g_fw || g_hw;
				wr_ok = rd_ok;
			end
			`MMFW_MODE_COS:
			begin
				rd_ok = g_cpu || g_cosi || g_fw || is_status_word_high || (g_hw && fw_lo_q[sub]);
				wr_ok = g_cpu || g_cosi || (g_hw && fw_hi_q[sub]);
			end
			`MMFW_MODE_USER:
			begin
				rd_ok = g_cpu || is_status_word_high || (g_hw && exec_hw_q[0]);
				wr_ok = g_cpu || (g_hw && exec_hw_q[1]);
			end
			default:
			begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
		ok = SFR_WE ? wr_ok : rd_ok;
		case (SFR_ADDR)
			`MMFW_A_TBL_PTR_LOW: own_rd = tbl_ptr_q[7:0];
			`MMFW_A_TBL_PTR_HIGH: own_rd = tbl_ptr_q[15:8];
			`MMFW_A_FW_CTRL_LOW: own_rd = fw_lo_q;
			`MMFW_A_FW_CTRL_HIGH: own_rd = fw_hi_q;
			`MMFW_A_XW_BASE_LOW: own_rd = xw_base_q[7:0];
			`MMFW_A_XW_BASE_HIGH: own_rd = xw_base_q[15:8];
			`MMFW_A_XW_SIZE_LOW: own_rd = xw_size_q[7:0];
			`MMFW_A_XW_SIZE_HIGH: own_rd = xw_size_q[15:8];
			default: own_rd = 8'h00;
		endcase
	end

	wire own_wr = SFR_REQ && SFR_WE && own && ok;

	always @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			tbl_ptr_q <= `MMFW_RST_TBL_PTR;
			fw_lo_q <= `MMFW_RST_FW_CTRL;
			fw_hi_q <= `MMFW_RST_FW_CTRL;
			xw_base_q <= `MMFW_RST_XW;
			xw_size_q <= `MMFW_RST_XW;
		end
		else if (own_wr)
		begin
			case (SFR_ADDR)
				`MMFW_A_TBL_PTR_LOW: tbl_ptr_q[7:0] <= SFR_WDATA;
				`MMFW_A_TBL_PTR_HIGH: tbl_ptr_q[15:8] <= SFR_WDATA;
				`MMFW_A_FW_CTRL_LOW: fw_lo_q <= SFR_WDATA;
				`MMFW_A_FW_CTRL_HIGH: fw_hi_q <= SFR_WDATA;
				`MMFW_A_XW_BASE_LOW: xw_base_q[7:0] <= SFR_WDATA;
				`MMFW_A_XW_BASE_HIGH: xw_base_q[15:8] <= SFR_WDATA;
				`MMFW_A_XW_SIZE_LOW: xw_size_q[7:0] <= SFR_WDATA;
				`MMFW_A_XW_SIZE_HIGH: xw_size_q[15:8] <= SFR_WDATA;
				default: tbl_ptr_q <= tbl_ptr_q;
			endcase
		end
	end

	// Two-stage answer: forward on the first edge, return data on the second.
	always @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			fwd_re_q <= 1'b0;
			fwd_we_q <= 1'b0;
			fwd_addr_q <= 8'h00;
			fwd_wdata_q <= 8'h00;
			s1_v_q <= 1'b0;
			s1_we_q <= 1'b0;
			s1_ok_q <= 1'b0;
			s1_own_q <= 1'b0;
			s1_rd_q <= 8'h00;
			sfr_rdata_q <= 8'h00;
			ack_q <= 1'b0;
			denied_q <= 1'b0;
		end
		else
		begin
			fwd_re_q <= SFR_REQ && !SFR_WE && ok && !own;
			fwd_we_q <= SFR_REQ && SFR_WE && ok && !own;
			if (SFR_REQ)
			begin
				fwd_addr_q <= SFR_ADDR;
				fwd_wdata_q <= SFR_WDATA;
			end
			s1_v_q <= SFR_REQ;
			s1_we_q <= SFR_WE;
			s1_ok_q <= ok;
			s1_own_q <= own;
			s1_rd_q <= own_rd;
			ack_q <= s1_v_q;
			denied_q <= s1_v_q && !s1_ok_q;
			if (s1_v_q && !s1_we_q && s1_ok_q)
				sfr_rdata_q <= s1_own_q ? s1_rd_q : SFR_FWD_RDATA;
			else
				sfr_rdata_q <= 8'h00;
		end
	end

	assign PHYS_REQ = phys_req_q;
	assign PHYS_WE = phys_we_q;
	assign PHYS_ADDR = phys_addr_q;
	assign MEM_DONE = done_q;
	assign MEM_FAULT = fault_q;
	assign SFR_FWD_RE = fwd_re_q;
	assign SFR_FWD_WE = fwd_we_q;
	assign SFR_FWD_ADDR = fwd_addr_q;
	assign SFR_FWD_WDATA = fwd_wdata_q;
	assign SFR_RDATA = sfr_rdata_q;
	assign SFR_ACK = ack_q;
	assign SFR_DENIED = denied_q;
	assign CPU_MODE = mode_q;
	assign EXEC_SEG = exec_seg_q;

endmodule // mmfw_unit

`default_nettype wire

//--- mmfw_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mmfw_unit_chk (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic INSTR_START,
	input wire logic [7:0] STATUS_WORD_HIGH,
	input wire logic [1:0] MODE_BITS,
	input wire logic [19:0] MEM_VADDR,
	input wire logic PHYS_REQ,
	input wire logic [19:0] PHYS_ADDR,
	input wire logic MEM_DONE,
	input wire logic MEM_FAULT,
	input wire logic SFR_REQ,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_FWD_RE,
	input wire logic SFR_FWD_WE,
	input wire logic [7:0] SFR_RDATA,
	input wire logic SFR_ACK,
	input wire logic SFR_DENIED,
	input wire logic [2:0] CPU_MODE
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	sfr_ack_lat_a: assert property (SFR_REQ |-> ##2 SFR_ACK)
		else $error("register answer late");
	deny_zero_a: assert property (SFR_DENIED |-> SFR_ACK && SFR_RDATA == 8'h00)
		else $error("denied read not zero");
	deny_no_fwd_a: assert property (SFR_DENIED |-> !$past(SFR_FWD_RE) && !$past(SFR_FWD_WE))
		else $error("denied access forwarded");
	seg_sys_only_a: assert property (SFR_REQ && SFR_ADDR[7:3] == 5'h14 && CPU_MODE != 3'h3
		&& !INSTR_START |-> ##2 SFR_DENIED) else $error("segment register open");
	cpu_open_a: assert property (SFR_REQ && SFR_ADDR[7:4] == 4'h8 |-> ##2 !SFR_DENIED)
		else $error("cpu register denied");
	mem_fault_a: assert property (MEM_FAULT |-> MEM_DONE && !PHYS_REQ)
		else $error("fault with grant");
	phys_grant_a: assert property (PHYS_REQ |-> MEM_DONE && !MEM_FAULT)
		else $error("grant outside check");
	sys_ident_a: assert property (PHYS_REQ && CPU_MODE != 3'h4 |-> PHYS_ADDR == $past(MEM_VADDR, 2))
		else $error("identity address wrong");
	mode_hold_a: assert property (!INSTR_START |=> $stable(CPU_MODE))
		else $error("mode changed mid instruction");
	sys_mode_a: assert property (INSTR_START && MODE_BITS == 2'h0 && STATUS_WORD_HIGH[7]
		&& !STATUS_WORD_HIGH[6] |=> CPU_MODE == 3'h3) else $error("system mode missed");
	boot_mode_a: assert property (INSTR_START && MODE_BITS[0] |=> CPU_MODE == 3'h0)
		else $error("boot mode missed");
endmodule // mmfw_unit_chk
bind mmfw_unit mmfw_unit_chk chk (.*);
`default_nettype wire

//--- mmfw_regspace.sv
`timescale 1ns/1ps
`default_nettype none
module mmfw_regspace (
	input wire logic clk,
	input wire logic re,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem_q [0:255];
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem_q[i] = i[7:0] ^ 8'h5A;
	end
	// Shows the inverse outside a forwarded read so stale data never looks right.
	assign rdata = re ? mem_q[addr] : ~mem_q[addr];
	always @(posedge clk)
	begin
		if (we)
			mem_q[addr] <= wdata;
	end
endmodule // mmfw_regspace
`default_nettype wire

//--- tb_mmfw_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmfw_defs.vh"
module tb_mmfw_unit;
	logic SYS_CLK = 0, RESET_N = 0, INSTR_START = 0, MEM_REQ = 0, TBL_WE = 0, SFR_REQ = 0;
	logic SFR_WE = 0, CFG_COS_PRESENT = 1;
	logic [7:0] STATUS_WORD_HIGH = 0, SFR_ADDR = 0, SFR_WDATA = 0;
	logic [1:0] MODE_BITS = 0, MEM_OP = 0;
	logic [19:0] MEM_VADDR = 0;
	logic [5:0] TBL_INDEX = 0;
	logic [`MMFW_ENT_W-1:0] TBL_WDATA = 0;
	wire logic PHYS_REQ, PHYS_WE, MEM_DONE, MEM_FAULT, fwd_re, fwd_we, SFR_ACK, SFR_DENIED;
	wire logic [19:0] PHYS_ADDR;
	wire logic [7:0] fwd_addr, fwd_wdata, fwd_rdata, SFR_RDATA;
	wire logic [2:0] CPU_MODE;
	wire logic [5:0] EXEC_SEG;
	int miscompares = 0, checked = 0, cm, ur = 0, uw = 0, n;
	int cee = 'h1000, cram = 'h400, wb = 0, ws = 0;
	int ref_sfr [256];
	int mbs [7] = '{1, 2, 0, 0, 0, 3, 0};
	int sws [7] = '{0, 0, 'h40, 'h80, 0, 'h80, 'hC0};
	int adrs [6] = '{'h85, 'h90, 'hA0, 'hA8, 'hB2, 'hC8};
	int ops [9] = '{0, 2, 1, 1, 1, 2, 0, 3, 0};
	int vas [9] = '{'h100, 'h10000, 'h10000, 'h40010, 'h41000, 'h80800, 'h80800, 'h41000, 'h80010};
	initial
	begin
		forever #50 SYS_CLK = ~SYS_CLK;
	end
	mmfw_unit dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .INSTR_START(INSTR_START),
		.STATUS_WORD_HIGH(STATUS_WORD_HIGH), .MODE_BITS(MODE_BITS),
		.CFG_COS_PRESENT(CFG_COS_PRESENT),
		.CFG_COS_EE_SIZE(20'h01000), .CFG_COS_RAM_SIZE(20'h00400), .MEM_REQ(MEM_REQ),
		.MEM_OP(MEM_OP), .MEM_VADDR(MEM_VADDR), .PHYS_REQ(PHYS_REQ), .PHYS_WE(PHYS_WE),
		.PHYS_ADDR(PHYS_ADDR), .MEM_DONE(MEM_DONE), .MEM_FAULT(MEM_FAULT), .TBL_WE(TBL_WE),
		.TBL_INDEX(TBL_INDEX), .TBL_WDATA(TBL_WDATA), .SFR_REQ(SFR_REQ), .SFR_WE(SFR_WE),
		.SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_FWD_RDATA(fwd_rdata),
		.SFR_FWD_RE(fwd_re), .SFR_FWD_WE(fwd_we), .SFR_FWD_ADDR(fwd_addr),
		.SFR_FWD_WDATA(fwd_wdata), .SFR_RDATA(SFR_RDATA), .SFR_ACK(SFR_ACK),
		.SFR_DENIED(SFR_DENIED), .CPU_MODE(CPU_MODE), .EXEC_SEG(EXEC_SEG));
	mmfw_regspace regs (.clk(SYS_CLK), .re(fwd_re), .we(fwd_we), .addr(fwd_addr),
		.wdata(fwd_wdata), .rdata(fwd_rdata));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task set_mode(input logic [1:0] mb, input logic [7:0] sw);
		MODE_BITS = mb;
		STATUS_WORD_HIGH = sw;
		INSTR_START = 1;
		cm = (mb == 2'h2) ? 1 : (mb != 2'h0) ? 0 : (sw[6] && CFG_COS_PRESENT) ? 2 : sw[7] ? 3 : 4;
		@(posedge SYS_CLK);
		#1 INSTR_START = 0;
		chk(CPU_MODE, cm);
	endtask
	function automatic int sfr_deny(int a, int w);
		if (a >= 'hA0 && a < 'hA8)
			return cm != 3;
		if (cm < 2 || (a >> 4) == 8)
			return 0;
		if (cm == 3)
			return a >= 'hB0 && a < 'hC0;
		if (a == 'h90)
			return w;
		if (a >= 'hC0)
			return cm == 4 ? (w ? !uw : !ur) : !ref_sfr['hA8 + w][(a >> 3) & 7];
		if (cm == 2 && a >= 'hA8 && a < 'hB0)
			return w;
		return !(cm == 2 && a >= 'hB0 && a < 'hB8);
	endfunction
	task sfr(input int w, input int a, input int dv);
		int d, den;
		d = dv < 0 ? $urandom & 'hFF : dv;
		den = sfr_deny(a, w);
		SFR_REQ = 1;
		SFR_WE = w[0];
		SFR_ADDR = a[7:0];
		SFR_WDATA = d[7:0];
		@(posedge SYS_CLK);
		#1 SFR_REQ = 0;
		@(posedge SYS_CLK);
		#1 chk({SFR_ACK, SFR_DENIED}, 2 + den);
		chk(SFR_RDATA, (den || w) ? 0 : ref_sfr[a]);
		if (!den && w)
			ref_sfr[a] = d;
	endtask
	function automatic int mem_ok(int op, int va);
		int ee, ram, cp;
		ee = va >= 'h40000 && va < 'h80000;
		ram = va >= 'h80000 && va < 'h90000;
		if (op == 3 || va >= 'h90000 || (op == 1 && !ee && !ram) || (op == 2 && ram))
			return 0;
		if (cm == 1)
			return 1;
		cp = ram ? va < 'h80000 + cram : ee ? va < 'h40000 + cee : va < 'h8000;
		if (cm == 2 && ram && !cp && op != 2 && va >= 'h80000 + wb && va < 'h80000 + wb + ws)
			return 1;
		return (cm == 3) ? !cp : cp;
	endfunction
	task mem(input int op, input int va, input int ok, input int pa, input int lat);
		MEM_OP = op[1:0];
		MEM_VADDR = va[19:0];
		MEM_REQ = 1;
		@(posedge SYS_CLK);
		#1 MEM_REQ = 0;
		n = 1;
		while (MEM_DONE !== 1'b1 && n < 300)
		begin
			@(posedge SYS_CLK);
			#1 n++;
		end
		chk(n, lat);
		chk({PHYS_REQ, MEM_FAULT}, ok ? 2 : 1);
		if (ok)
			chk({PHYS_WE, PHYS_ADDR}, {op == 1, pa[19:0]});
	endtask
	initial
	begin
		#2000000;
		miscompares++;
		report_and_stop;
	end
	initial
	begin
		for (int i = 0; i < 256; i++)
			ref_sfr[i] = (i >= 'hA0 && i < 'hB0) ? 0 : i ^ 'h5A;
		void'($urandom(32'h95678798));
		repeat (6) @(posedge SYS_CLK);
		#1 RESET_N = 1;
		@(posedge SYS_CLK);
		// The exchange window is set up in system mode and used from contactless mode.
		#1 set_mode(0, 'h80);
		sfr(1, 'hA9, 'hFF);
		sfr(1, 'hAB, 'h08);
		sfr(1, 'hAD, 'h01);
		sfr(0, 'hAD, -1);
		wb = 'h800;
		ws = 'h100;
		set_mode(0, 'h40);
		mem(1, 'h808F0, 1, 'h808F0, 2);
		mem(1, 'h80900, 0, 0, 2);
		$display("test window done");
		// The second pass runs the variant without the contactless system.
		for (int v = 0; v < 2; v++)
		begin
			CFG_COS_PRESENT = v == 0;
			cee = v ? 'h80 : 'h1000;
			cram = v ? 0 : 'h400;
			repeat (3) @(posedge SYS_CLK);
			for (int m = 0; m < 7; m++)
			begin
				#1 set_mode(mbs[m], sws[m]);
				foreach (adrs[j])
				begin
					sfr(0, adrs[j], -1);
					sfr(1, adrs[j], adrs[j] == 'hA0 ? 0 : -1);
					sfr(0, adrs[j], -1);
				end
				if (cm != 4)
					foreach (ops[j])
						mem(ops[j], vas[j], mem_ok(ops[j], vas[j]), vas[j], 2);
			end
		end
		$display("test modes done");
		set_mode(0, 'h80);
		sfr(1, 'hA1, 'h10);
		TBL_WE = 1;
		TBL_INDEX = 1;
		TBL_WDATA = {20'h1F000, 20'h01FFF, 20'h01000, 5'h1D};
		@(posedge SYS_CLK);
		#1 TBL_INDEX = 2;
		TBL_WDATA = {20'h0E000, 20'h02FFF, 20'h02000, 5'h01};
		@(posedge SYS_CLK);
		#1 TBL_WE = 0;
		set_mode(0, 0);
		// A table write from user mode must be ignored, so entry 3 stays disabled.
		TBL_WE = 1;
		TBL_INDEX = 3;
		TBL_WDATA = {20'h00000, 20'h03FFF, 20'h03000, 5'h01};
		@(posedge SYS_CLK);
		#1 TBL_WE = 0;
		mem(2, 'h01010, 1, 'h20010, 6);
		chk(EXEC_SEG, 1);
		mem(1, 'h01010, 0, 0, 6);
		mem(0, 'h02200, 0, 0, 8);
		mem(0, 'h02800, 1, 'h10800, 8);
		mem(0, 'h03000, 0, 0, 130);
		ur = 1;
		uw = 1;
		sfr(0, 'hC8, -1);
		sfr(1, 'hC8, -1);
		sfr(0, 'hC8, -1);
		$display("test user done");
		report_and_stop;
	end
endmodule // tb_mmfw_unit
`default_nettype wire
